/* verilog/rcc_defs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words, byte addresses
// Notes: included by every design module and the testbench; the package and the interface do not include it
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH
`define RCC_OFF_CFGCAL 8'h00
`define RCC_OFF_PADCFG 8'h04
`define RCC_OFF_ALCFG 8'h08
`define RCC_OFF_MINUTES_SECONDS_VALUE 8'h0C
`define RCC_OFF_EVENT 8'h10
`define RCC_OFF_STATUS 8'h14
`define RCC_OFF_MASK 8'h18
`define RCC_OFF_ALVALH 8'h1C
`define RCC_CFG_RESET 16'h0000
`define RCC_PAD_RESET 16'h0000
`define RCC_AL_RESET 16'h0000
`define RCC_BIT_EN 15
`define RCC_BIT_WREN 13
`define RCC_BIT_HALF 11
`define RCC_BIT_OE 10
`define RCC_BIT_SECSEL 1
`define RCC_BIT_TTL 0
`define RCC_BIT_ALEN 15
`define RCC_BIT_CHIME 14
`define RCC_CFG_WMASK 16'hA7FF
`define RCC_PAD_WMASK 16'h0003
`define RCC_TRIM_STEP 4
`define RCC_TICKS_PER_MIN 16'd60
`define RCC_ST_ALARM 0
`define RCC_ST_MINUTE 1
`define RCC_ST_HALF 2
`define RCC_AXI_OKAY 2'b00
`define RCC_AXI_SLVERR 2'b10
`endif

/* verilog/rcc_pkg.sv */
// Purpose: shared types of the clock configuration block
// Assumes: nothing beyond the defs header
// Notes: types only; numbers live in rcc_defs.svh
package rcc_pkg;
    typedef enum logic [3:0] {
        RCC_EVERY_HALF, RCC_EVERY_SEC, RCC_EVERY_10SEC, RCC_EVERY_MIN,
        RCC_EVERY_10MIN, RCC_EVERY_HOUR, RCC_EVERY_DAY, RCC_EVERY_WEEK,
        RCC_EVERY_MONTH, RCC_EVERY_YEAR, RCC_RSV_A, RCC_RSV_B,
        RCC_RSV_C, RCC_RSV_D, RCC_RSV_E, RCC_RSV_F
    } rcc_interval_t;
    typedef enum logic [1:0] {
        RCC_BUS_IDLE, RCC_BUS_WRESP, RCC_BUS_RDATA
    } rcc_bus_state_t;
endpackage

/* verilog/rcc_trim_if.sv */
// Purpose: carries trim requests and pulse adjustments between modules
// Assumes: single clock
// Notes: trim is the signed drift field
`timescale 1ns/1ps
interface rcc_trim_if;
    logic [7:0] trim;
    logic minute_pulse;
    logic add_pulse;
    logic drop_pulse;
    logic busy;
    modport ctrl (output trim, output minute_pulse,
                  input add_pulse, input drop_pulse, input busy);
    modport trimmer (input trim, input minute_pulse,
                     output add_pulse, output drop_pulse, output busy);
endinterface

/* verilog/rcc_trimmer.sv */
// Purpose: spreads drift correction pulses after each minute mark
// Assumes: minute_pulse one cycle wide
// Notes: four pulses per code step, signed
`timescale 1ns/1ps
module rcc_trimmer (
    input wire logic clk_in,
    input wire logic por_in,
    rcc_trim_if.trimmer tr
);
    import rcc_pkg::*;
    `include "rcc_defs.svh"

    typedef struct packed {
        logic [9:0] left;
        logic neg;
        logic add;
        logic drop;
    } rcc_trim_state_t;

    rcc_trim_state_t s, next_s;

    // magnitude of correction in pulses
    function automatic logic [9:0] trim_pulses(input logic [7:0] t);
        logic [7:0] mag;
        mag = t[7] ? 8'(-t) : t;
        if (t == 8'h80) begin
            return 10'd512;
        end
        return 10'(mag) * 10'(`RCC_TRIM_STEP);
    endfunction

    // load at minute, then one pulse per cycle
    always_comb begin
        next_s = s;
        next_s.add = 1'b0;
        next_s.drop = 1'b0;
        if (tr.minute_pulse && s.left == 10'd0) begin
            next_s.left = trim_pulses(tr.trim); // [RL1] [RL2] [RL3] [RL4]
            next_s.neg = tr.trim[7]; // [RL5]
        end else if (s.left != 10'd0) begin
            next_s.left = s.left - 10'd1;
            next_s.add = ~s.neg;
            next_s.drop = s.neg;
        end
    end

    // state register, power-on reset only
    always_ff @(posedge clk_in) begin
        if (por_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tr.add_pulse = s.add;
    assign tr.drop_pulse = s.drop;
    assign tr.busy = (s.left != 10'd0);
endmodule

/* verilog/rcc_alarm_seq.sv */
// Purpose: alarm enable, repeat count and window pointer sequencing
// Assumes: alarm_event from the comparison datapath, one cycle
// Notes: software writes take priority over pointer stepping
`timescale 1ns/1ps
module rcc_alarm_seq (
    input wire logic clk_in,
    input wire logic por_in,
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    input wire logic valh_access_in,
    input wire logic alarm_event_in,
    output logic [15:0] cfg_out,
    output logic fired_out
);
    import rcc_pkg::*;
    `include "rcc_defs.svh"

    typedef struct packed {
        logic [15:0] cfg;
        logic fired;
    } rcc_alarm_state_t;

    rcc_alarm_state_t s, next_s;

    // event handling, pointer stepping, software write
    always_comb begin
        next_s = s;
        next_s.fired = 1'b0;
        if (alarm_event_in && s.cfg[`RCC_BIT_ALEN]) begin
            next_s.fired = 1'b1;
            if (s.cfg[7:0] != 8'h00) begin
                next_s.cfg[7:0] = s.cfg[7:0] - 8'h01;
            end else if (s.cfg[`RCC_BIT_CHIME]) begin
                next_s.cfg[7:0] = 8'hFF; // [RL17]
            end else begin
                next_s.cfg[`RCC_BIT_ALEN] = 1'b0; // [RL16]
            end
        end
        if (valh_access_in && s.cfg[9:8] != 2'b00) begin
            next_s.cfg[9:8] = s.cfg[9:8] - 2'b01; // [RL15]
        end
        if (wr_in) begin
            next_s.cfg = wdata_in; // [RL14]
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (por_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cfg_out = s.cfg;
    assign fired_out = s.fired;
endmodule

/* verilog/rcc_top.sv */
// Purpose: clock configuration, drift trim and pin source over AXI4-Lite
// Assumes: SYS_RST_IN is the power-on reset
// Notes: timekeeping counters live outside; ticks arrive as pulses
`timescale 1ns/1ps
`include "rcc_defs.svh"

// Behaviour
// RL1 - largest positive trim code adds 508 pulses per minute
// RL2 - each positive trim step adds four pulses per minute
// RL3 - zero trim code adds and removes nothing
// RL4 - most negative trim code removes 512 pulses per minute
// RL5 - all ones trim code removes four pulses per minute
// RL6 - configuration register cleared only by power-on reset
// RL7 - module enable writable only while value write unlock is set
// RL8 - half second flag read only, cleared by minutes seconds low write
// RL9 - source select one puts seconds clock on the pin
// RL10 - source select zero puts alarm pulse on the pin
// RL11 - pin driven only while its output enable bit is set
// RL12 - buffer select one picks TTL, zero picks Schmitt buffers
// RL13 - pad register bits 15 to 2 read zero, ignore writes
// RL14 - four-bit mask selects alarm interval, upper codes reserved
// RL15 - alarm pointer decrements on high byte access, stops at zero
// RL16 - alarm enable clears after event when count zero, chime off
// RL17 - with chime, repeat count wraps from zero to FFh
module rcc_top (
    input wire logic CORE_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic SECOND_TICK_IN,
    input wire logic HALF_TICK_IN,
    input wire logic ALARM_EVENT_IN,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic CLOCK_PIN_OUT,
    output logic CLOCK_PIN_OE_OUT,
    output logic MODULE_ENABLE_OUT,
    output logic TTL_BUFFERS_OUT,
    output logic [3:0] ALARM_INTERVAL_OUT,
    output logic ADD_PULSE_OUT,
    output logic DROP_PULSE_OUT,
    output logic MINUTES_SECONDS_VALUE_LOW_WRITE_OUT,
    output logic IRQ_OUT
);
    import rcc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        rcc_bus_state_t bus;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] cfgcal;
        logic [1:0] pad;
        logic [15:0] sec_count;
        logic sec_clk;
        logic [2:0] status;
        logic [2:0] mask;
        logic pin;
        logic pin_oe;
        logic irq;
        logic add;
        logic drop;
        logic minutes_seconds_value_wr;
    } rcc_state_t;

    rcc_state_t s, next_s;

    logic al_wr;
    logic valh_acc;
    logic [15:0] al_cfg;
    logic al_fired;
    rcc_trim_if tif ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // merge write data by byte enables into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // known register offset: aligned words 00 to 1C
    function automatic logic mapped(input logic [7:0] a);
        logic low;
        low = a[7:5] == 3'b000;
        return low && a[1:0] == 2'b00;
    endfunction

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    assign tif.trim = s.cfgcal[7:0];
    assign tif.minute_pulse = SECOND_TICK_IN &&
                              s.sec_count == `RCC_TICKS_PER_MIN - 16'd1;

    rcc_trimmer u_trim (
        .clk_in(CORE_CLK_IN),
        .por_in(SYS_RST_IN),
        .tr(tif.trimmer)
    );

    rcc_alarm_seq u_alarm (
        .clk_in(CORE_CLK_IN),
        .por_in(SYS_RST_IN),
        .wr_in(al_wr),
        .wdata_in(merge16(al_cfg, s.wdata, s.wstrb)),
        .valh_access_in(valh_acc),
        .alarm_event_in(ALARM_EVENT_IN),
        .cfg_out(al_cfg),
        .fired_out(al_fired)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // bus handshakes, register writes, events, pin
    always_comb begin
        logic do_wr;
        logic [15:0] nc;
        logic [2:0] ev;
        next_s = s;
        do_wr = 1'b0;
        nc = 16'h0000;
        ev = 3'b000;
        al_wr = 1'b0;
        valh_acc = 1'b0;
        next_s.minutes_seconds_value_wr = 1'b0;
        next_s.awready = 1'b0;
        next_s.wready = 1'b0;
        next_s.arready = 1'b0;
        case (s.bus)
            RCC_BUS_IDLE: begin
                if (S_AXI_AWVALID_IN && !s.aw_got && !s.awready) begin
                    next_s.awready = 1'b1;
                end
                if (S_AXI_WVALID_IN && !s.w_got && !s.wready) begin
                    next_s.wready = 1'b1;
                end
                if (s.awready) begin
                    next_s.aw_got = 1'b1;
                    next_s.awaddr = S_AXI_AWADDR_IN;
                end
                if (s.wready) begin
                    next_s.w_got = 1'b1;
                    next_s.wdata = S_AXI_WDATA_IN;
                    next_s.wstrb = S_AXI_WSTRB_IN;
                end
                if (s.aw_got && s.w_got) begin
                    do_wr = 1'b1;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    next_s.bvalid = 1'b1;
                    next_s.bresp = mapped(s.awaddr) ? `RCC_AXI_OKAY
                                                    : `RCC_AXI_SLVERR;
                    next_s.bus = RCC_BUS_WRESP;
                end else if (S_AXI_ARVALID_IN && !s.arready &&
                             !s.aw_got && !s.w_got && !s.awready &&
                             !s.wready && !S_AXI_AWVALID_IN) begin
                    next_s.arready = 1'b1;
                end
                if (s.arready) begin
                    next_s.rvalid = 1'b1;
                    next_s.rresp = `RCC_AXI_OKAY;
                    next_s.rdata = 32'h0000_0000;
                    case (S_AXI_ARADDR_IN)
                        `RCC_OFF_CFGCAL: next_s.rdata[15:0] = s.cfgcal;
                        `RCC_OFF_PADCFG: next_s.rdata[1:0] = s.pad; // [RL13]
                        `RCC_OFF_ALCFG: next_s.rdata[15:0] = al_cfg;
                        `RCC_OFF_MINUTES_SECONDS_VALUE: next_s.rdata[15:0] = s.sec_count;
                        `RCC_OFF_EVENT: next_s.rdata[2:0] = s.status;
                        `RCC_OFF_STATUS: next_s.rdata[2:0] = s.status;
                        `RCC_OFF_MASK: next_s.rdata[2:0] = s.mask;
                        `RCC_OFF_ALVALH: valh_acc = 1'b1; // [RL15]
                        default: next_s.rresp = `RCC_AXI_SLVERR;
                    endcase
                    next_s.bus = RCC_BUS_RDATA;
                end
            end
            RCC_BUS_WRESP: begin
                if (S_AXI_BREADY_IN) begin
                    next_s.bvalid = 1'b0;
                    next_s.bus = RCC_BUS_IDLE;
                end
            end
            RCC_BUS_RDATA: begin
                if (S_AXI_RREADY_IN) begin
                    next_s.rvalid = 1'b0;
                    next_s.bus = RCC_BUS_IDLE;
                end
            end
            default: next_s.bus = RCC_BUS_IDLE;
        endcase

        // hardware state of the configuration register
        if (HALF_TICK_IN) begin
            next_s.cfgcal[`RCC_BIT_HALF] = ~s.cfgcal[`RCC_BIT_HALF];
        end
        if (do_wr) begin
            case (s.awaddr)
                `RCC_OFF_CFGCAL: begin
                    nc = merge16(s.cfgcal, s.wdata, s.wstrb);
                    nc = (nc & `RCC_CFG_WMASK) |
                         (next_s.cfgcal & ~`RCC_CFG_WMASK);
                    if (!s.cfgcal[`RCC_BIT_WREN]) begin
                        nc[`RCC_BIT_EN] = s.cfgcal[`RCC_BIT_EN]; // [RL7]
                    end
                    next_s.cfgcal = nc;
                end
                `RCC_OFF_PADCFG: begin
                    nc = merge16({14'h0000, s.pad}, s.wdata, s.wstrb);
                    next_s.pad = nc[1:0]; // [RL13]
                end
                `RCC_OFF_ALCFG: al_wr = 1'b1;
                `RCC_OFF_MINUTES_SECONDS_VALUE: begin
                    if (s.wstrb[0]) begin
                        next_s.cfgcal[`RCC_BIT_HALF] = 1'b0; // [RL8]
                        next_s.minutes_seconds_value_wr = 1'b1;
                    end
                end
                `RCC_OFF_ALVALH: valh_acc = 1'b1; // [RL15]
                `RCC_OFF_MASK: next_s.mask = s.wdata[2:0];
                default: nc = 16'h0000;
            endcase
        end

        // seconds clock and minute count
        if (SECOND_TICK_IN) begin
            next_s.sec_clk = ~s.sec_clk;
            next_s.sec_count = tif.minute_pulse ? 16'd0
                                                : s.sec_count + 16'd1;
        end

        // sticky events, set wins over write-one clear
        ev[`RCC_ST_ALARM] = al_fired;
        ev[`RCC_ST_MINUTE] = tif.minute_pulse;
        ev[`RCC_ST_HALF] = HALF_TICK_IN;
        if (do_wr && (s.awaddr == `RCC_OFF_STATUS ||
                      s.awaddr == `RCC_OFF_EVENT) && s.wstrb[0]) begin
            next_s.status = s.status & ~s.wdata[2:0];
        end
        next_s.status = next_s.status | ev;
        next_s.irq = |(next_s.status & next_s.mask);

        // pin source and enable
        next_s.pin_oe = next_s.cfgcal[`RCC_BIT_OE]; // [RL11]
        if (!next_s.pin_oe) begin
            next_s.pin = 1'b0; // [RL11]
        end else if (next_s.pad[`RCC_BIT_SECSEL]) begin
            next_s.pin = next_s.sec_clk; // [RL9]
        end else begin
            next_s.pin = al_fired; // [RL10]
        end
        next_s.add = tif.add_pulse;
        next_s.drop = tif.drop_pulse;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // SYS_RST_IN acts as the power-on reset
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            s <= '0;
            s.cfgcal <= `RCC_CFG_RESET; // [RL6]
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign S_AXI_AWREADY_OUT = s.awready;
    assign S_AXI_WREADY_OUT = s.wready;
    assign S_AXI_BVALID_OUT = s.bvalid;
    assign S_AXI_BRESP_OUT = s.bresp;
    assign S_AXI_ARREADY_OUT = s.arready;
    assign S_AXI_RVALID_OUT = s.rvalid;
    assign S_AXI_RDATA_OUT = s.rdata;
    assign S_AXI_RRESP_OUT = s.rresp;
    assign CLOCK_PIN_OUT = s.pin;
    assign CLOCK_PIN_OE_OUT = s.pin_oe;
    assign MODULE_ENABLE_OUT = s.cfgcal[`RCC_BIT_EN];
    assign TTL_BUFFERS_OUT = s.pad[`RCC_BIT_TTL]; // [RL12]
    assign ALARM_INTERVAL_OUT = al_cfg[13:10]; // [RL14]
    assign ADD_PULSE_OUT = s.add;
    assign DROP_PULSE_OUT = s.drop;
    assign MINUTES_SECONDS_VALUE_LOW_WRITE_OUT = s.minutes_seconds_value_wr;
    assign IRQ_OUT = s.irq;
endmodule

/* testbench/rcc_asserts.sv */
// Purpose: port checks of the clock config block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto rcc_top
`timescale 1ns/1ps
`include "rcc_defs.svh"
module rcc_asserts (
    input wire logic CORE_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_WREADY_OUT,
    input wire logic [1:0] S_AXI_BRESP_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic CLOCK_PIN_OUT,
    input wire logic CLOCK_PIN_OE_OUT,
    input wire logic MODULE_ENABLE_OUT,
    input wire logic TTL_BUFFERS_OUT,
    input wire logic ADD_PULSE_OUT,
    input wire logic DROP_PULSE_OUT,
    input wire logic MINUTES_SECONDS_VALUE_LOW_WRITE_OUT
);
    logic [9:0] run_add;
    logic [9:0] run_drop;
    logic [2:0] wr_hist;
    // --------------------
    // pulse runs, write history
    // --------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            run_add <= 10'h000;
            run_drop <= 10'h000;
            wr_hist <= 3'h0;
        end else begin
            run_add <= ADD_PULSE_OUT ? run_add + 10'h001 : 10'h000;
            run_drop <= DROP_PULSE_OUT ? run_drop + 10'h001 : 10'h000;
            wr_hist <= {wr_hist[1:0], S_AXI_WREADY_OUT};
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // --------------------
    // properties
    // --------------------
    pin_gate_a: assert property (!CLOCK_PIN_OE_OUT &&
        !$past(CLOCK_PIN_OE_OUT) |-> !CLOCK_PIN_OUT)
        else $error("pin driven while off");
    add_max_a: assert property (run_add <= 10'h1FC)
        else $error("too many adds");
    drop_max_a: assert property (run_drop <= 10'h200)
        else $error("too many drops");
    trim_sign_a: assert property (!(ADD_PULSE_OUT && DROP_PULSE_OUT))
        else $error("add and drop together");
    ttl_cause_a: assert property ($changed(TTL_BUFFERS_OUT) |->
        |wr_hist) else $error("buffer select moved");
    enable_cause_a: assert property ($changed(MODULE_ENABLE_OUT) |->
        |wr_hist) else $error("enable moved");
    minutes_seconds_value_cause_a: assert property (MINUTES_SECONDS_VALUE_LOW_WRITE_OUT |->
        |wr_hist) else $error("minutes_seconds_value strobe unasked");
    bvalid_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
        |=> S_AXI_BVALID_OUT)
        else $error("write response dropped early");
    rvalid_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT)
        else $error("read data dropped early");
    aw_pulse_a: assert property (S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
        else $error("address ready held");
    bresp_code_a: assert property (S_AXI_BVALID_OUT |-> S_AXI_BRESP_OUT
        inside {`RCC_AXI_OKAY, `RCC_AXI_SLVERR})
        else $error("bad write response code");
    add_seen_c: cover property (ADD_PULSE_OUT);
    drop_seen_c: cover property (DROP_PULSE_OUT);
    pin_seen_c: cover property (CLOCK_PIN_OUT);
    err_seen_c: cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT[1]);
endmodule

bind rcc_top rcc_asserts u_chk (.*);

/* testbench/rtc_calib_output_alarm_cfg_tb.sv */
// Purpose: self-checking bench of the clock config block
// Assumes: bench is the AXI4-Lite master; ticks are pulses
// Notes: a monitor checks bus answers from queues
`timescale 1ns/1ps
`include "rcc_defs.svh"
module rtc_calib_output_alarm_cfg_tb;
    import rcc_pkg::*;
    localparam logic [1:0] OK = `RCC_AXI_OKAY;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [16:0] lk [5] = '{17'h0_8000, 17'h0_2000,
        17'h1_A000, 17'h0_0000, 17'h0_8000};
    localparam logic [27:0] tt [5] = '{{8'h01, 10'h004, 10'h000},
        {8'h7F, 10'h1FC, 10'h000}, {8'h00, 10'h000, 10'h000},
        {8'hFF, 10'h000, 10'h004}, {8'h80, 10'h000, 10'h200}};
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic rvalid, pin, pin_oe, mod_en, ttl, addp, dropp, msw, irq;
    logic [2:0] ev = 3'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, v;
    logic [1:0] bresp, rresp;
    logic [3:0] intv;
    logic [65:0] rq [$];
    logic [65:0] e;
    logic [1:0] bq [$];
    int err_count = 0, samples_checked = 0, cyc = 0, npin, nadd, ndrop;
    int nmsw = 0;
    int seed = 32'h420c780f;

    rcc_top DUT (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
        .SECOND_TICK_IN(ev[0]), .HALF_TICK_IN(ev[1]),
        .ALARM_EVENT_IN(ev[2]), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h3),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
        .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .CLOCK_PIN_OUT(pin), .CLOCK_PIN_OE_OUT(pin_oe),
        .MODULE_ENABLE_OUT(mod_en), .TTL_BUFFERS_OUT(ttl),
        .ALARM_INTERVAL_OUT(intv), .ADD_PULSE_OUT(addp),
        .DROP_PULSE_OUT(dropp), .MINUTES_SECONDS_VALUE_LOW_WRITE_OUT(msw),
        .IRQ_OUT(irq));

    // --------------------
    // helpers
    // --------------------
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic ok, input string s);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
            input logic [31:0] m, input logic [1:0] r);
        rq.push_back({r, m, x});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int k, input int cnt);
        repeat (cnt) begin
            ev[k] <= 1'b1;
            @(posedge clk);
            ev[k] <= 1'b0;
            repeat (9) @(posedge clk);
        end
    endtask
    task automatic rst_seq;
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    // monitor: check answers, count pulses
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            final_report();
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            chk((rdata & e[63:32]) === e[31:0] && rresp === e[65:64],
                "read data");
        end
        if (bvalid && bready)
            chk(bresp === bq.pop_front(), "write response");
        if (pin === 1'b1) npin++;
        if (addp === 1'b1) nadd++;
        if (dropp === 1'b1) ndrop++;
        if (msw === 1'b1) nmsw++;
    end

    // --------------------
    // scenarios
    // --------------------
    initial begin
        rst_seq();
        for (int i = 0; i < 12; i += 4) begin
            rd(8'(i), 0, ALL, OK);
        end
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`RCC_OFF_PADCFG, v, OK);
            rd(`RCC_OFF_PADCFG, v & 32'h0000_0003, ALL, OK);
            chk(ttl === v[0], "buffer select");
        end
        foreach (lk[i]) begin
            wr(`RCC_OFF_CFGCAL, 32'(lk[i][15:0]), OK);
            chk(mod_en === lk[i][16], "enable lock");
        end
        $display("test registers done");
        pulse(1, 1);
        rd(`RCC_OFF_CFGCAL, 32'h0000_0800, 32'h0000_0800, OK);
        wr(`RCC_OFF_MINUTES_SECONDS_VALUE, 0, OK);
        chk(nmsw === 1, "minutes_seconds_value strobe");
        rd(`RCC_OFF_CFGCAL, 0, 32'h0000_0800, OK);
        wr(`RCC_OFF_CFGCAL, 32'h0000_0800, OK);
        rd(`RCC_OFF_CFGCAL, 0, 32'h0000_0800, OK);
        $display("test half flag done");
        wr(`RCC_OFF_MASK, 1, OK);
        wr(`RCC_OFF_PADCFG, 0, OK);
        wr(`RCC_OFF_CFGCAL, 32'h0000_0400, OK);
        wr(`RCC_OFF_ALCFG, 32'h0000_8000, OK);
        npin = 0;
        pulse(2, 1);
        chk(npin === 1, "alarm pin");
        chk(irq === 1'b1, "irq raised");
        rd(`RCC_OFF_ALCFG, 0, 32'h0000_8000, OK);
        wr(`RCC_OFF_STATUS, 1, OK);
        chk(irq === 1'b0, "irq cleared");
        wr(`RCC_OFF_MASK, 0, OK);
        wr(`RCC_OFF_ALCFG, 32'h0000_C000, OK);
        pulse(2, 1);
        chk(irq === 1'b0, "irq masked");
        rd(`RCC_OFF_STATUS, 1, 1, OK);
        rd(`RCC_OFF_ALCFG, 32'h0000_C0FF, 32'h0000_C0FF, OK);
        wr(`RCC_OFF_PADCFG, 2, OK);
        npin = 0;
        pulse(0, 4);
        chk(npin !== 0, "seconds pin");
        wr(`RCC_OFF_CFGCAL, 0, OK);
        npin = 0;
        pulse(0, 4);
        chk(npin === 0 && pin_oe === 1'b0, "pin disabled");
        $display("test pin and alarm done");
        for (int i = 0; i < 10; i++) begin
            wr(`RCC_OFF_ALCFG, 32'(i) << 10, OK);
            chk(intv === 4'(i), "alarm interval");
        end
        wr(`RCC_OFF_ALCFG, 32'h0000_0300, OK);
        for (int k = 0; k < 4; k++) begin
            rd(`RCC_OFF_ALVALH, 0, 0, OK);
            rd(`RCC_OFF_ALCFG, 32'(k < 3 ? 2 - k : 0) << 8, ALL, OK);
        end
        wr(8'h40, 1, `RCC_AXI_SLVERR);
        rd(8'h40, 0, ALL, `RCC_AXI_SLVERR);
        $display("test alarm fields done");
        foreach (tt[i]) begin
            rst_seq();
            wr(`RCC_OFF_CFGCAL, 32'h0000_2000 | 32'(tt[i][27:20]), OK);
            wr(`RCC_OFF_CFGCAL, 32'h0000_A000 | 32'(tt[i][27:20]), OK);
            nadd = 0;
            ndrop = 0;
            pulse(0, 60);
            repeat (600) @(posedge clk);
            chk(nadd === 32'(tt[i][19:10]) && ndrop === 32'(tt[i][9:0]),
                "trim count");
        end
        $display("test trim done");
        final_report();
    end
endmodule
